// ### rtl/sfc_map.svh
// sfc constants: framing bytes, modes and frame buffer size
// How it works
// - mode 0 transparent default, 1 framed, 2 escaped
// - receiver drops bytes before start delimiter
// - bad or failed-checksum frame: device end discards it entirely, host end streams it and pulses rx_bad only if its type is known
// - every frame starts with delimiter 0x7E
// - length MSB first, data, one checksum
// - length counts frame data bytes only
// - first data byte is frame type
// - checksum is 0xFF minus low sum byte
// - data plus checksum low byte equals 0xFF
// - escaped mode: unescaped 0x7E restarts frame
// - escape 0x7E 0x7D 0x11 0x13 after delimiter
// - escape is 0x7D then byte XOR 0x20
// - escaping covers length, data and checksum
// - length and checksum use unescaped values
// - host filters frames with unknown types
// - types below 0x80 requests, else responses
// - multi-byte values sent big-endian
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH
`define SFC_DELIM 8'h7E
`define SFC_ESC 8'h7D
`define SFC_XON 8'h11
`define SFC_XOFF 8'h13
`define SFC_ESC_XOR 8'h20
`define SFC_CSUM_OK 8'hFF
`define SFC_RESP_MIN 8'h80
`define SFC_MODE_TRANSP 2'h0
`define SFC_MODE_FRAMED 2'h1
`define SFC_MODE_ESCAPED 2'h2
`define SFC_BUF_AW 8
`define SFC_BUF_DEPTH 256
`define SFC_MAX_LEN 16'h0100
`endif

// ### rtl/sfc_pkg.sv
// sfc types: receive and transmit state encodings
package sfc_pkg;
   typedef enum logic [2:0] {
      SFC_HUNT = 3'h0,
      SFC_LEN_HI = 3'h1,
      SFC_LEN_LO = 3'h2,
      SFC_DATA = 3'h3,
      SFC_CSUM = 3'h4,
      SFC_PLAY = 3'h5
   } sfc_rx_state_e;
   typedef enum logic [2:0] {
      SFC_TX_IDLE = 3'h0,
      SFC_TX_LEN_HI = 3'h1,
      SFC_TX_LEN_LO = 3'h2,
      SFC_TX_DATA = 3'h3,
      SFC_TX_CSUM = 3'h4
   } sfc_tx_state_e;
endpackage: sfc_pkg

// ### rtl/sfc_link_if.sv
// sfc link interface: one byte stream each way with valid and ready
`timescale 1ns/100ps
`default_nettype none
interface sfc_link_if;
   logic h2d_valid;
   logic [7:0] h2d_data;
   logic h2d_ready;
   logic d2h_valid;
   logic [7:0] d2h_data;
   logic d2h_ready;
   modport dev (input h2d_valid, input h2d_data, output h2d_ready,
                output d2h_valid, output d2h_data, input d2h_ready);
   modport host (output h2d_valid, output h2d_data, input h2d_ready,
                 input d2h_valid, input d2h_data, output d2h_ready);
endinterface: sfc_link_if
`default_nettype wire

// ### rtl/sfc_frame_tx.sv
// sfc transmit framer with optional escaping, shared by both ends
`timescale 1ns/100ps
`default_nettype none
`include "sfc_map.svh"
module sfc_frame_tx (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [1:0] mode,
   input wire logic in_valid,
   input wire logic [7:0] in_data,
   input wire logic [15:0] in_len,
   output logic in_ready,
   output logic out_valid,
   output logic [7:0] out_data,
   input wire logic out_ready
);
   sfc_pkg::sfc_tx_state_e state_reg, state_next;
   logic hold_valid_reg;
   logic [7:0] hold_data_reg;
   logic [15:0] hold_len_reg;
   logic out_valid_reg;
   logic [7:0] out_data_reg;
   logic esc_pend_reg;
   logic [7:0] esc_byte_reg;
   logic [15:0] len_reg;
   logic [15:0] cnt_reg;
   logic [7:0] sum_reg;
   logic [7:0] raw;
   logic emit;
   logic use_hold;
   logic delim;
   wire framed = (mode == `SFC_MODE_FRAMED) || (mode == `SFC_MODE_ESCAPED);
   wire escaped = (mode == `SFC_MODE_ESCAPED);
   wire slot = !out_valid_reg || out_ready;
   wire take_hold = in_valid && !hold_valid_reg;
   wire special = (raw == `SFC_DELIM) || (raw == `SFC_ESC) || (raw == `SFC_XON) || (raw == `SFC_XOFF);
   wire need_esc = escaped && !delim && special;
   wire leave_idle = (state_reg == sfc_pkg::SFC_TX_IDLE) && (state_next != sfc_pkg::SFC_TX_IDLE);

   always_comb begin
      state_next = state_reg;
      raw = 8'h00;
      emit = 1'b0;
      use_hold = 1'b0;
      delim = 1'b0;
      if (slot && !esc_pend_reg) begin
         unique case (state_reg)
            sfc_pkg::SFC_TX_IDLE: begin
               if (hold_valid_reg && framed) begin
                  raw = `SFC_DELIM;
                  delim = 1'b1;
                  emit = 1'b1;
                  state_next = sfc_pkg::SFC_TX_LEN_HI;
               end else if (hold_valid_reg) begin
                  raw = hold_data_reg;
                  emit = 1'b1;
                  use_hold = 1'b1;
               end
            end
            sfc_pkg::SFC_TX_LEN_HI: begin
               raw = len_reg[15:8];
               emit = 1'b1;
               state_next = sfc_pkg::SFC_TX_LEN_LO;
            end
            sfc_pkg::SFC_TX_LEN_LO: begin
               raw = len_reg[7:0];
               emit = 1'b1;
               state_next = (len_reg == 16'h0000) ? sfc_pkg::SFC_TX_CSUM : sfc_pkg::SFC_TX_DATA;
            end
            sfc_pkg::SFC_TX_DATA: begin
               if (hold_valid_reg) begin
                  raw = hold_data_reg;
                  emit = 1'b1;
                  use_hold = 1'b1;
                  if (cnt_reg == len_reg - 16'h0001) begin
                     state_next = sfc_pkg::SFC_TX_CSUM;
                  end
               end
            end
            sfc_pkg::SFC_TX_CSUM: begin
               raw = `SFC_CSUM_OK - sum_reg;
               emit = 1'b1;
               state_next = sfc_pkg::SFC_TX_IDLE;
            end
            default: state_next = sfc_pkg::SFC_TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_reg <= sfc_pkg::SFC_TX_IDLE;
         out_valid_reg <= 1'b0;
         out_data_reg <= 8'h00;
         esc_pend_reg <= 1'b0;
         esc_byte_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         if (slot) begin
            out_valid_reg <= esc_pend_reg || emit;
         end
         if (slot && esc_pend_reg) begin
            out_data_reg <= esc_byte_reg;
            esc_pend_reg <= 1'b0;
         end else if (emit) begin
            out_data_reg <= need_esc ? `SFC_ESC : raw;
            esc_pend_reg <= need_esc;
            esc_byte_reg <= raw ^ `SFC_ESC_XOR;
         end
      end
   end

   // one-byte holding stage keeps the user ready a plain flop
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         hold_valid_reg <= 1'b0;
         hold_data_reg <= 8'h00;
         hold_len_reg <= 16'h0000;
      end else if (use_hold) begin
         hold_valid_reg <= 1'b0;
      end else if (take_hold) begin
         hold_valid_reg <= 1'b1;
         hold_data_reg <= in_data;
         hold_len_reg <= in_len;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         len_reg <= 16'h0000;
         cnt_reg <= 16'h0000;
         sum_reg <= 8'h00;
      end else if (leave_idle) begin
         len_reg <= hold_len_reg;
         cnt_reg <= 16'h0000;
         sum_reg <= 8'h00;
      end else if (use_hold && state_reg == sfc_pkg::SFC_TX_DATA) begin
         cnt_reg <= cnt_reg + 16'h0001;
         sum_reg <= sum_reg + raw;
      end
   end

   assign in_ready = !hold_valid_reg;
   assign out_valid = out_valid_reg;
   assign out_data = out_data_reg;
endmodule: sfc_frame_tx
`default_nettype wire

// ### rtl/sfc_dev_end.sv
// sfc device end: buffered deframer with checksum discard, plus framer
`timescale 1ns/100ps
`default_nettype none
`include "sfc_map.svh"
module sfc_dev_end (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [1:0] framing_mode_select,
   sfc_link_if.dev link,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_first,
   output logic rx_last,
   input wire logic rx_ready,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic [15:0] tx_len,
   output logic tx_ready
);
   sfc_pkg::sfc_rx_state_e state_reg, state_next;
   logic ready_reg;
   logic esc_reg;
   logic [15:0] len_reg;
   logic [15:0] cnt_reg;
   logic [15:0] rd_reg;
   logic [7:0] sum_reg;
   logic ov_reg;
   logic [7:0] od_reg;
   logic first_reg;
   logic last_reg;
   logic ov_next;
   // whole frame is held until its checksum is known
   logic [7:0] buf_mem [0:`SFC_BUF_DEPTH-1];

   wire framed = (framing_mode_select == `SFC_MODE_FRAMED) || (framing_mode_select == `SFC_MODE_ESCAPED);
   wire escaped = (framing_mode_select == `SFC_MODE_ESCAPED);
   wire acc = link.h2d_valid && ready_reg;
   wire [7:0] raw = link.h2d_data;
   wire is_delim = (raw == `SFC_DELIM);
   wire esc_mark = escaped && !esc_reg && (raw == `SFC_ESC);
   wire resync = escaped && !esc_reg && is_delim;
   wire [7:0] b = esc_reg ? (raw ^ `SFC_ESC_XOR) : raw;
   wire [7:0] sum_new = sum_reg + b;
   wire [15:0] len_full = {len_reg[15:8], b};
   wire byte_in = acc && framed && !esc_mark;
   wire pass = acc && !framed;
   wire out_take = ov_reg && rx_ready;
   wire in_play = (state_reg == sfc_pkg::SFC_PLAY);
   wire play_load = in_play && (!ov_reg || out_take);
   wire play_more = rd_reg != len_reg;
   wire start = byte_in && (resync || (state_reg == sfc_pkg::SFC_HUNT && is_delim));
   wire data_wr = byte_in && !resync && (state_reg == sfc_pkg::SFC_DATA);

   always_comb begin
      state_next = state_reg;
      if (!framed) begin
         state_next = sfc_pkg::SFC_HUNT;
      end else if (byte_in && resync) begin
         state_next = sfc_pkg::SFC_LEN_HI;
      end else if (byte_in) begin
         unique case (state_reg)
            sfc_pkg::SFC_HUNT: begin
               if (is_delim) begin
                  state_next = sfc_pkg::SFC_LEN_HI;
               end
            end
            sfc_pkg::SFC_LEN_HI: state_next = sfc_pkg::SFC_LEN_LO;
            sfc_pkg::SFC_LEN_LO: begin
               if (len_full == 16'h0000) begin
                  state_next = sfc_pkg::SFC_CSUM;
               end else if (len_full > `SFC_MAX_LEN) begin
                  state_next = sfc_pkg::SFC_HUNT;
               end else begin
                  state_next = sfc_pkg::SFC_DATA;
               end
            end
            sfc_pkg::SFC_DATA: begin
               if (cnt_reg == len_reg - 16'h0001) begin
                  state_next = sfc_pkg::SFC_CSUM;
               end
            end
            sfc_pkg::SFC_CSUM: begin
               state_next = (sum_new == `SFC_CSUM_OK) ? sfc_pkg::SFC_PLAY : sfc_pkg::SFC_HUNT;
            end
            sfc_pkg::SFC_PLAY: state_next = sfc_pkg::SFC_PLAY;
            default: state_next = sfc_pkg::SFC_HUNT;
         endcase
      end else if (play_load && !play_more) begin
         state_next = sfc_pkg::SFC_HUNT;
      end
   end

   always_comb begin
      ov_next = ov_reg && !rx_ready;
      if (pass || (play_load && play_more)) begin
         ov_next = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_reg <= sfc_pkg::SFC_HUNT;
         ready_reg <= 1'b0;
         esc_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         // link is stalled while a frame plays out, so the buffer is never overwritten
         ready_reg <= (state_next != sfc_pkg::SFC_PLAY) && !ov_next;
         if (acc) begin
            esc_reg <= esc_mark;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         len_reg <= 16'h0000;
         cnt_reg <= 16'h0000;
         sum_reg <= 8'h00;
      end else if (start) begin
         cnt_reg <= 16'h0000;
         sum_reg <= 8'h00;
      end else if (byte_in && state_reg == sfc_pkg::SFC_LEN_HI) begin
         len_reg[15:8] <= b;
      end else if (byte_in && state_reg == sfc_pkg::SFC_LEN_LO) begin
         len_reg[7:0] <= b;
      end else if (data_wr) begin
         cnt_reg <= cnt_reg + 16'h0001;
         sum_reg <= sum_new;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (data_wr) begin
         buf_mem[cnt_reg[`SFC_BUF_AW-1:0]] <= b;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rd_reg <= 16'h0000;
      end else if (!in_play) begin
         rd_reg <= 16'h0000;
      end else if (play_load && play_more) begin
         rd_reg <= rd_reg + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ov_reg <= 1'b0;
         od_reg <= 8'h00;
         first_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         ov_reg <= ov_next;
         if (pass) begin
            od_reg <= raw;
            first_reg <= 1'b0;
            last_reg <= 1'b0;
         end else if (play_load && play_more) begin
            od_reg <= buf_mem[rd_reg[`SFC_BUF_AW-1:0]];
            first_reg <= (rd_reg == 16'h0000);
            last_reg <= (rd_reg == len_reg - 16'h0001);
         end
      end
   end

   sfc_frame_tx u_tx (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .mode(framing_mode_select),
      .in_valid(tx_valid),
      .in_data(tx_data),
      .in_len(tx_len),
      .in_ready(tx_ready),
      .out_valid(link.d2h_valid),
      .out_data(link.d2h_data),
      .out_ready(link.d2h_ready)
   );

   assign link.h2d_ready = ready_reg;
   assign rx_valid = ov_reg;
   assign rx_data = od_reg;
   assign rx_first = first_reg;
   assign rx_last = last_reg;
endmodule: sfc_dev_end
`default_nettype wire

// ### rtl/sfc_host_end.sv
// sfc host end: streaming deframer with type filter and verdict, plus framer
`timescale 1ns/100ps
`default_nettype none
`include "sfc_map.svh"
module sfc_host_end (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [1:0] framing_mode_select,
   sfc_link_if.host link,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_first,
   output logic rx_last,
   output logic rx_good,
   output logic rx_bad,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic [15:0] tx_len,
   output logic tx_ready
);
   sfc_pkg::sfc_rx_state_e state_reg, state_next;
   logic ready_reg;
   logic esc_reg;
   logic keep_reg;
   logic [15:0] len_reg;
   logic [15:0] cnt_reg;
   logic [7:0] sum_reg;
   logic valid_reg, first_reg, last_reg, good_reg, bad_reg;
   logic [7:0] data_reg;

   wire framed = (framing_mode_select == `SFC_MODE_FRAMED) || (framing_mode_select == `SFC_MODE_ESCAPED);
   wire escaped = (framing_mode_select == `SFC_MODE_ESCAPED);
   wire acc = link.d2h_valid && ready_reg;
   wire [7:0] raw = link.d2h_data;
   wire esc_mark = escaped && !esc_reg && (raw == `SFC_ESC);
   wire resync = escaped && !esc_reg && (raw == `SFC_DELIM);
   wire [7:0] b = esc_reg ? (raw ^ `SFC_ESC_XOR) : raw;
   wire [7:0] sum_new = sum_reg + b;
   wire byte_in = acc && framed && !esc_mark;
   wire in_data = byte_in && !resync && (state_reg == sfc_pkg::SFC_DATA);
   wire in_csum = byte_in && !resync && (state_reg == sfc_pkg::SFC_CSUM);
   wire is_first = in_data && (cnt_reg == 16'h0000);
   wire known = b >= `SFC_RESP_MIN;
   wire keep_now = is_first ? known : keep_reg;
   wire broken = byte_in && resync && keep_reg && (state_reg == sfc_pkg::SFC_DATA || state_reg == sfc_pkg::SFC_CSUM);

   always_comb begin
      state_next = state_reg;
      if (!framed) begin
         state_next = sfc_pkg::SFC_HUNT;
      end else if (byte_in && resync) begin
         state_next = sfc_pkg::SFC_LEN_HI;
      end else if (byte_in) begin
         unique case (state_reg)
            sfc_pkg::SFC_HUNT: begin
               if (raw == `SFC_DELIM) begin
                  state_next = sfc_pkg::SFC_LEN_HI;
               end
            end
            sfc_pkg::SFC_LEN_HI: state_next = sfc_pkg::SFC_LEN_LO;
            sfc_pkg::SFC_LEN_LO: begin
               state_next = ({len_reg[15:8], b} == 16'h0000) ? sfc_pkg::SFC_CSUM : sfc_pkg::SFC_DATA;
            end
            sfc_pkg::SFC_DATA: begin
               if (cnt_reg == len_reg - 16'h0001) begin
                  state_next = sfc_pkg::SFC_CSUM;
               end
            end
            sfc_pkg::SFC_CSUM: state_next = sfc_pkg::SFC_HUNT;
            default: state_next = sfc_pkg::SFC_HUNT;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_reg <= sfc_pkg::SFC_HUNT;
         ready_reg <= 1'b0;
         esc_reg <= 1'b0;
         keep_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ready_reg <= 1'b1;
         if (acc) begin
            esc_reg <= esc_mark;
         end
         if (byte_in && state_next == sfc_pkg::SFC_LEN_HI) begin
            keep_reg <= 1'b0;
         end else if (is_first) begin
            keep_reg <= known;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         len_reg <= 16'h0000;
         cnt_reg <= 16'h0000;
         sum_reg <= 8'h00;
      end else if (byte_in && state_next == sfc_pkg::SFC_LEN_HI) begin
         cnt_reg <= 16'h0000;
         sum_reg <= 8'h00;
      end else if (byte_in && state_reg == sfc_pkg::SFC_LEN_HI) begin
         len_reg[15:8] <= b;
      end else if (byte_in && state_reg == sfc_pkg::SFC_LEN_LO) begin
         len_reg[7:0] <= b;
      end else if (in_data) begin
         cnt_reg <= cnt_reg + 16'h0001;
         sum_reg <= sum_new;
      end
   end

   // no buffer here: the verdict pulse tells the user to drop what it streamed
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         valid_reg <= 1'b0;
         data_reg <= 8'h00;
         first_reg <= 1'b0;
         last_reg <= 1'b0;
         good_reg <= 1'b0;
         bad_reg <= 1'b0;
      end else begin
         valid_reg <= (acc && !framed) || (in_data && keep_now);
         if (acc) begin
            data_reg <= framed ? b : raw;
         end
         first_reg <= is_first;
         last_reg <= in_data && (cnt_reg == len_reg - 16'h0001);
         good_reg <= in_csum && keep_reg && (sum_new == `SFC_CSUM_OK);
         bad_reg <= (in_csum && keep_reg && (sum_new != `SFC_CSUM_OK)) || broken;
      end
   end

   sfc_frame_tx u_tx (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .mode(framing_mode_select),
      .in_valid(tx_valid),
      .in_data(tx_data),
      .in_len(tx_len),
      .in_ready(tx_ready),
      .out_valid(link.h2d_valid),
      .out_data(link.h2d_data),
      .out_ready(link.h2d_ready)
   );

   assign link.d2h_ready = ready_reg;
   assign rx_valid = valid_reg;
   assign rx_data = data_reg;
   assign rx_first = first_reg & valid_reg;
   assign rx_last = last_reg & valid_reg;
   assign rx_good = good_reg;
   assign rx_bad = bad_reg;
endmodule: sfc_host_end
`default_nettype wire

// ### test/sfc_link_monitor.sv
// sfc link checker: hold, reset and escape rules on both byte streams
`timescale 1ns/100ps
`default_nettype none
module sfc_link_monitor (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [1:0] framing_mode_select,
   input wire logic h2d_valid,
   input wire logic [7:0] h2d_data,
   input wire logic h2d_ready,
   input wire logic d2h_valid,
   input wire logic [7:0] d2h_data,
   input wire logic d2h_ready
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   wire logic esc = framing_mode_select == 2'h2;
   wire logic h_tk = h2d_valid && h2d_ready;
   wire logic d_tk = d2h_valid && d2h_ready;
   logic h_esc_reg;
   logic d_esc_reg;
   // a pending escape means the next taken byte must be a flipped special value
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         h_esc_reg <= 1'b0;
         d_esc_reg <= 1'b0;
      end else begin
         if (h_tk)
            h_esc_reg <= esc && h2d_data == 8'h7D && !h_esc_reg;
         if (d_tk)
            d_esc_reg <= esc && d2h_data == 8'h7D && !d_esc_reg;
      end
   end
   property p_h_hold; h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data); endproperty
   a_h_hold: assert property (p_h_hold) else $error("h2d byte not held");
   property p_d_hold; d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data); endproperty
   a_d_hold: assert property (p_d_hold) else $error("d2h byte not held");
   property p_rst_idle; $rose(rstn) |-> !h2d_valid && !d2h_valid; endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("byte sent during reset");
   property p_rst_rdy; $rose(rstn) |=> h2d_ready && d2h_ready; endproperty
   a_rst_rdy: assert property (p_rst_rdy) else $error("receiver not ready after reset");
   property p_h_esc; h_tk && h_esc_reg |-> h2d_data inside {8'h5E, 8'h5D, 8'h31, 8'h33}; endproperty
   a_h_esc: assert property (p_h_esc) else $error("h2d bad escaped byte");
   property p_d_esc; d_tk && d_esc_reg |-> d2h_data inside {8'h5E, 8'h5D, 8'h31, 8'h33}; endproperty
   a_d_esc: assert property (p_d_esc) else $error("d2h bad escaped byte");
   property p_h_raw; h_tk && esc && !h_esc_reg |-> !(h2d_data inside {8'h11, 8'h13}); endproperty
   a_h_raw: assert property (p_h_raw) else $error("h2d special byte unescaped");
   property p_d_raw; d_tk && esc && !d_esc_reg |-> !(d2h_data inside {8'h11, 8'h13}); endproperty
   a_d_raw: assert property (p_d_raw) else $error("d2h special byte unescaped");
   c_h_esc: cover property (h_tk && h_esc_reg);
   c_d_esc: cover property (d_tk && d_esc_reg);
   c_d_delim: cover property (d_tk && d2h_data == 8'h7E);
endmodule: sfc_link_monitor
`default_nettype wire

// ### test/test_serial_api_frame_codec.sv
// sfc bench: both ends on one link, plus a device end fed faulty byte streams
`timescale 1ns/100ps
`default_nettype none
module test_serial_api_frame_codec;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [1:0] mode = 2'h0;
   logic [1:0] sel = 2'h0;
   logic tx_v = 1'b0;
   logic [7:0] tx_d = 8'h00;
   logic [15:0] tx_l = 16'h0000;
   logic drx_v, drx_f, drx_l, dtx_rdy, hrx_v, hrx_f, hrx_l, good, bad, htx_rdy, frx_v;
   logic [7:0] drx_d, hrx_d, frx_d;
   logic [9:0] qw[$], qd[$], qr[$], qh[$], qf[$], ew[$], er[$];
   logic [7:0] b[$];
   int n_errors = 0;
   int checked = 0;
   int cyc = 0;
   int n_good = 0;
   int n_bad = 0;
   int g0;
   // mode, length, then up to three bytes; a length above 3 sends 1, 2, 3 ...
   logic [39:0] rows [7] = '{40'h0101230000, 40'h0102231100, 40'h0202231100, 40'h02037E7D13,
      40'h020201ED00, 40'h0211000000, 40'h00015A0000};
   sfc_link_if link ();
   sfc_link_if flink ();
   wire logic dtx_v = tx_v && sel == 2'h1;
   wire logic htx_v = tx_v && sel == 2'h0;
   wire logic rdy = sel == 2'h2 ? flink.h2d_ready : sel == 2'h1 ? dtx_rdy : htx_rdy;
   // device users take bytes only every other cycle, so held outputs and link stalls are exercised
   wire logic drdy = cyc[0];
   assign flink.h2d_valid = tx_v && sel == 2'h2;
   assign flink.h2d_data = flink.h2d_valid ? tx_d : ~tx_d;
   assign flink.d2h_ready = 1'b1;
   always #20 clk_sys = ~clk_sys;
   sfc_dev_end sfc_dev_end_inst (.clk_sys(clk_sys), .rstn(rstn), .framing_mode_select(mode), .link(link),
      .rx_valid(drx_v), .rx_data(drx_d), .rx_first(drx_f), .rx_last(drx_l), .rx_ready(drdy),
      .tx_valid(dtx_v), .tx_data(tx_d), .tx_len(tx_l), .tx_ready(dtx_rdy));
   sfc_host_end sfc_host_end_inst (.clk_sys(clk_sys), .rstn(rstn), .framing_mode_select(mode), .link(link),
      .rx_valid(hrx_v), .rx_data(hrx_d), .rx_first(hrx_f), .rx_last(hrx_l), .rx_good(good), .rx_bad(bad),
      .tx_valid(htx_v), .tx_data(tx_d), .tx_len(tx_l), .tx_ready(htx_rdy));
   // fault end: only its receive side is exercised
   sfc_dev_end sfc_dev_end_inst2 (.clk_sys(clk_sys), .rstn(rstn), .framing_mode_select(mode), .link(flink),
      .rx_valid(frx_v), .rx_data(frx_d), .rx_first(), .rx_last(), .rx_ready(drdy),
      .tx_valid(1'b0), .tx_data(tx_d), .tx_len(tx_l), .tx_ready());
   sfc_link_monitor sfc_link_monitor_inst (.clk_sys(clk_sys), .rstn(rstn), .framing_mode_select(mode),
      .h2d_valid(link.h2d_valid), .h2d_data(link.h2d_data), .h2d_ready(link.h2d_ready),
      .d2h_valid(link.d2h_valid), .d2h_data(link.d2h_data), .d2h_ready(link.d2h_ready));
   task automatic end_of_test();
      $display("errors %0d checked %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask: end_of_test
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (link.h2d_valid && link.h2d_ready)
         qw.push_back({2'h0, link.h2d_data});
      if (link.d2h_valid && link.d2h_ready)
         qd.push_back({2'h0, link.d2h_data});
      if (drx_v && drdy)
         qr.push_back({drx_f, drx_l, drx_d});
      if (hrx_v)
         qh.push_back({hrx_f, hrx_l, hrx_d});
      if (frx_v && drdy)
         qf.push_back({2'h0, frx_d});
      if (good)
         n_good++;
      if (bad)
         n_bad++;
      if (cyc == 30000) begin
         n_errors++;
         end_of_test();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask: chk
   task automatic cmpq(input logic [9:0] a[$], input logic [9:0] e[$]);
      chk(16'(a.size()), 16'(e.size()));
      for (int i = 0; i < a.size() && i < e.size(); i++)
         chk(16'(a[i]), 16'(e[i]));
   endtask: cmpq
   task automatic wt(ref logic [9:0] q[$], input int n);
      for (int k = 0; k < 400 && q.size() < n; k++)
         @(posedge clk_sys);
      repeat (6) @(posedge clk_sys);
      #1;
   endtask: wt
   // each byte is held until the end's ready is seen high at a rising edge
   task automatic send(input logic [1:0] t, input logic [7:0] sb[$]);
      sel = t;
      tx_l = 16'(sb.size());
      for (int i = 0; i < sb.size(); i++) begin
         tx_v = 1'b1;
         tx_d = sb[i];
         while (!rdy) @(posedge clk_sys) #1;
         @(posedge clk_sys) #1;
      end
      tx_v = 1'b0;
   endtask: send
   function automatic void put(input logic [1:0] m, input logic [7:0] v, ref logic [9:0] q[$]);
      if (m == 2'h2 && v inside {8'h7E, 8'h7D, 8'h11, 8'h13}) begin
         q.push_back(10'h07D);
         q.push_back({2'h0, v ^ 8'h20});
      end else
         q.push_back({2'h0, v});
   endfunction: put
   function automatic void frm(input logic [1:0] m, ref logic [9:0] w[$], ref logic [9:0] r[$]);
      logic [7:0] s;
      s = 8'h00;
      w.delete();
      r.delete();
      if (m != 2'h0) begin
         w.push_back(10'h07E);
         put(m, 8'(b.size() >> 8), w);
         put(m, 8'(b.size()), w);
      end
      foreach (b[i]) begin
         put(m, b[i], w);
         s += b[i];
         r.push_back({m != 2'h0 && i == 0, m != 2'h0 && i == b.size() - 1, b[i]});
      end
      if (m != 2'h0)
         put(m, 8'hFF - s, w);
   endfunction: frm
   initial begin
      repeat (4) @(posedge clk_sys);
      chk(16'({dtx_rdy, htx_rdy, drx_v, link.h2d_valid, link.d2h_valid}), 16'h0018);
      #1 rstn = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      foreach (rows[r]) begin
         mode = rows[r][33:32];
         b.delete();
         for (int i = 0; i < rows[r][31:24]; i++)
            b.push_back(rows[r][31:24] > 3 ? 8'(i + 1) : 8'(rows[r] >> (16 - 8 * i)));
         qw.delete();
         qd.delete();
         qr.delete();
         qh.delete();
         g0 = n_good;
         send(2'h0, b);
         wt(qr, b.size());
         frm(mode, ew, er);
         cmpq(qw, ew);
         cmpq(qr, er);
         b[0] = b[0] | 8'h80;
         send(2'h1, b);
         wt(qh, b.size());
         frm(mode, ew, er);
         cmpq(qd, ew);
         cmpq(qh, er);
         chk(16'(n_good - g0), 16'(mode != 2'h0));
      end
      mode = 2'h1;
      qf.delete();
      send(2'h2, {8'h55, 8'hAA, 8'h7E, 8'h00, 8'h01, 8'h23, 8'hDD, 8'h7E, 8'h00, 8'h01, 8'h23, 8'hDC});
      wt(qf, 1);
      cmpq(qf, {10'h023});
      mode = 2'h2;
      qf.delete();
      send(2'h2, {8'h7E, 8'h00, 8'h02, 8'h23, 8'h7E, 8'h00, 8'h01, 8'h42, 8'hBD});
      wt(qf, 1);
      cmpq(qf, {10'h042});
      mode = 2'h1;
      qh.delete();
      g0 = n_good;
      send(2'h1, {8'h23, 8'h11});
      wt(qh, 0);
      chk(16'(qh.size()), 16'h0000);
      chk(16'(n_good - g0), 16'h0000);
      chk(16'(n_bad), 16'h0000);
      end_of_test();
   end
endmodule: test_serial_api_frame_codec
`default_nettype wire
